// ===== rtl/pqt_pkg.sv
// Summary of operation
// - Runt: first level crossed twice in a row, second level never crossed.
// - Runt range any: fire on every runt whatever its duration.
// - Runt range longer/shorter: duration above/below runt width.
// - Runt within: width minus/plus delta inclusive; outside: beyond band.
// - Window enter: fire when signal moves into the band between levels.
// - Window exit: fire when signal moves out of the band.
// - Window stay inside: fire on time spent between levels, time-qualified.
// - Time condition used only for stay inside/outside, not enter/exit.
// - Window within: stay at least width-delta and at most width+delta.
// - Window outside: stay shorter than width-delta or longer than width+delta.
// - Window shorter: limit crossed before width time elapsed.
// - Window longer: limit crossed only after width time elapsed.
// - Timeout: fire after no expected level transition for the set time.
// - Timeout range picks stays high, stays low, or either state.
// - Interval: time between successive rising or successive falling edges.
// - Interval either slope: both edges used at once.
// - Interval within/outside: inside/outside width plus or minus delta.
// - Interval shorter/longer: below/above interval width.
// - Slew: start timing at lower (rising) or upper (falling) crossing.
// - Slew: stop at second level; elapsed time is the transition time.
// - Slew within/outside: inside/outside limit plus or minus delta.
// - Slew shorter/longer: below/above the slew limit.
// - Slew either slope: rising and falling both accepted, first one wins.
`default_nettype none
package pqt_pkg;

   // Register byte offsets
   localparam int unsigned PQT_AW         = 5;
   localparam logic [4:0]  PQT_OFF_CTRL   = 5'h00;
   localparam logic [4:0]  PQT_OFF_WIDTH  = 5'h04;
   localparam logic [4:0]  PQT_OFF_DELTA  = 5'h08;
   localparam logic [4:0]  PQT_OFF_MEAS   = 5'h0C;
   localparam logic [4:0]  PQT_OFF_COUNT  = 5'h10;
   localparam logic [4:0]  PQT_OFF_STATUS = 5'h14;

   typedef enum logic [2:0] {
      PQT_MODE_RUNT, PQT_MODE_WINDOW, PQT_MODE_TIMEOUT,
      PQT_MODE_INTERVAL, PQT_MODE_SLEW
   } pqt_mode_t;

   typedef enum logic [2:0] {
      PQT_RNG_ANY, PQT_RNG_LONGER, PQT_RNG_SHORTER,
      PQT_RNG_WITHIN, PQT_RNG_OUTSIDE
   } pqt_range_t;

   typedef enum logic [1:0] {
      PQT_SLOPE_POS, PQT_SLOPE_NEG, PQT_SLOPE_EITHER
   } pqt_slope_t;

   typedef enum logic [1:0] {
      PQT_VC_ENTER, PQT_VC_EXIT, PQT_VC_STAY_IN, PQT_VC_STAY_OUT
   } pqt_vcond_t;

   typedef enum logic [1:0] {
      PQT_TO_HIGH, PQT_TO_LOW, PQT_TO_EITHER
   } pqt_tor_t;

   // Control word, enable in bit 0
   typedef struct packed {
      pqt_tor_t   tor;
      pqt_vcond_t vcond;
      pqt_slope_t slope;
      pqt_range_t range;
      pqt_mode_t  mode;
      logic       enable;
   } pqt_cfg_t;

   localparam int unsigned PQT_CFG_W   = $bits(pqt_cfg_t);
   localparam pqt_cfg_t    PQT_CFG_RST = '0;

   // Comparator indications: above upper, above lower, above single level
   typedef struct packed {
      logic upper;
      logic lower;
      logic level;
   } pqt_cmp_t;

   localparam logic [31:0] PQT_REG_RST = 32'h0000_0000;
   localparam int unsigned PQT_ST_RUN  = 0;
   localparam int unsigned PQT_ST_SEEN = 1;
   localparam int unsigned PQT_ST_DIR  = 2;

endpackage : pqt_pkg
`default_nettype wire

// ===== rtl/pqt_core.sv
`timescale 1ns/10ps
`default_nettype none
module pqt_core #(
   parameter int unsigned CNT_W = 32
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        ce,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [pqt_pkg::PQT_AW-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   input  wire pqt_pkg::pqt_cmp_t           cmp_i,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic                             trig_o
);
   import pqt_pkg::*;

   // Register state
   pqt_cfg_t          cfg_q;
   logic [CNT_W-1:0]  width_q;
   logic [CNT_W-1:0]  delta_q;
   logic [CNT_W-1:0]  meas_q;
   logic [31:0]       tcount_q;
   logic [31:0]       prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   logic              trig_q;

   // Measurement state
   pqt_cmp_t          cmp_q;
   logic              seen_q;
   logic              run_q;
   logic              dir_q;
   logic [CNT_W-1:0]  cnt_q;
   // Fall-to-fall timing, only used for interval with either slope
   logic              alt_run_q;
   logic [CNT_W-1:0]  alt_cnt_q;

   // Combinational event results
   logic              start;
   logic              start_dir;
   logic              stop;
   logic              done;
   logic              fire;
   logic              alt_start;
   logic              alt_done;

   // Bus decode
   logic              access;
   logic              wr;
   logic              wr_ctrl;
   logic              restart;

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Range test shared by every timed mode except timeout
   function automatic logic qualify(input logic [CNT_W-1:0] dur,
                                    input pqt_range_t       rng,
                                    input logic [CNT_W-1:0] w,
                                    input logic [CNT_W-1:0] d);
      logic [CNT_W:0] lo;
      logic [CNT_W:0] hi;
      logic           in_band;
      // Low bound clamps at zero instead of wrapping
      lo = (w > d) ? {1'b0, w - d} : '0;
      hi = {1'b0, w} + {1'b0, d};
      in_band = ({1'b0, dur} >= lo) && ({1'b0, dur} <= hi);
      unique case (rng)
         PQT_RNG_ANY:     qualify = 1'b1;
         PQT_RNG_LONGER:  qualify = dur > w;
         PQT_RNG_SHORTER: qualify = dur < w;
         PQT_RNG_WITHIN:  qualify = in_band;
         PQT_RNG_OUTSIDE: qualify = !in_band;
         default:         qualify = 1'b0;
      endcase
   endfunction

   // Edges only count once a previous sample exists
   logic lo_rise, lo_fall, up_rise, up_fall, lv_rise, lv_fall;
   logic in_now, in_was, reg_now, reg_was, to_match;
   assign lo_rise = seen_q & cmp_i.lower & ~cmp_q.lower;
   assign lo_fall = seen_q & ~cmp_i.lower & cmp_q.lower;
   assign up_rise = seen_q & cmp_i.upper & ~cmp_q.upper;
   assign up_fall = seen_q & ~cmp_i.upper & cmp_q.upper;
   assign lv_rise = seen_q & cmp_i.level & ~cmp_q.level;
   assign lv_fall = seen_q & ~cmp_i.level & cmp_q.level;
   assign in_now  = cmp_i.lower & ~cmp_i.upper;
   assign in_was  = cmp_q.lower & ~cmp_q.upper;
   assign reg_now = (cfg_q.vcond == PQT_VC_STAY_OUT) ? ~in_now : in_now;
   assign reg_was = (cfg_q.vcond == PQT_VC_STAY_OUT) ? ~in_was : in_was;

   // Timeout: which held state is being timed
   always_comb begin
      unique case (cfg_q.tor)
         PQT_TO_HIGH: to_match = cmp_i.level;
         PQT_TO_LOW:  to_match = ~cmp_i.level;
         default:     to_match = 1'b1;
      endcase
   end

   // Per-mode crossing sequencer
   always_comb begin
      logic pos_ok;
      logic neg_ok;
      logic sel_edge;
      pos_ok    = cfg_q.slope != PQT_SLOPE_NEG;
      neg_ok    = cfg_q.slope != PQT_SLOPE_POS;
      sel_edge  = 1'b0;
      start     = 1'b0;
      start_dir = 1'b0;
      stop      = 1'b0;
      done      = 1'b0;
      fire      = 1'b0;
      alt_start = 1'b0;
      alt_done  = 1'b0;
      unique case (cfg_q.mode)
         PQT_MODE_RUNT: begin
            if (run_q) begin
               // Dir 0 enters from below, dir 1 from above
               if (!dir_q && up_rise) begin
                  stop = 1'b1;
               end else if (!dir_q && lo_fall) begin
                  done = 1'b1;
               end else if (dir_q && lo_fall) begin
                  stop = 1'b1;
               end else if (dir_q && up_rise) begin
                  done = 1'b1;
               end
            end else if (pos_ok && lo_rise && !cmp_i.upper) begin
               start = 1'b1;
            end else if (neg_ok && up_fall && cmp_i.lower) begin
               start     = 1'b1;
               start_dir = 1'b1;
            end
            stop = stop | done;
            fire = done && qualify(cnt_q, cfg_q.range, width_q, delta_q);
         end
         PQT_MODE_WINDOW: begin
            unique case (cfg_q.vcond)
               PQT_VC_ENTER: fire = seen_q & in_now & ~in_was;
               PQT_VC_EXIT:  fire = seen_q & ~in_now & in_was;
               default: begin
                  // Stay time is judged when the region is left
                  if (run_q && !reg_now) begin
                     done = 1'b1;
                     stop = 1'b1;
                  end else if (seen_q && reg_now && !reg_was) begin
                     start = 1'b1;
                  end
                  fire = done && qualify(cnt_q, cfg_q.range, width_q,
                                         delta_q);
               end
            endcase
         end
         PQT_MODE_TIMEOUT: begin
            if (seen_q && to_match && (lv_rise || lv_fall || !run_q)) begin
               start = 1'b1;
            end else if (!to_match) begin
               stop = 1'b1;
            end
            // Counter counts on past the limit, so this fires once
            fire = run_q && !start && to_match && (cnt_q == width_q);
         end
         PQT_MODE_INTERVAL: begin
            unique case (cfg_q.slope)
               PQT_SLOPE_POS: sel_edge = lv_rise;
               PQT_SLOPE_NEG: sel_edge = lv_fall;
               default: begin
                  // Rise-to-rise and fall-to-fall timed side by side
                  sel_edge  = lv_rise;
                  alt_start = lv_fall;
                  alt_done  = lv_fall & alt_run_q;
               end
            endcase
            if (sel_edge) begin
               done  = run_q;
               start = 1'b1;
            end
            fire = (done && qualify(cnt_q, cfg_q.range, width_q, delta_q))
                   || (alt_done && qualify(alt_cnt_q, cfg_q.range, width_q,
                                           delta_q));
         end
         PQT_MODE_SLEW: begin
            if (run_q) begin
               // Dir 0 rising: lower to upper; dir 1 falling
               if (!dir_q && up_rise) begin
                  done = 1'b1;
               end else if (!dir_q && lo_fall) begin
                  stop = 1'b1;
               end else if (dir_q && lo_fall) begin
                  done = 1'b1;
               end else if (dir_q && up_rise) begin
                  stop = 1'b1;
               end
            end else if (pos_ok && lo_rise && !cmp_i.upper) begin
               start = 1'b1;
            end else if (neg_ok && up_fall && cmp_i.lower) begin
               start     = 1'b1;
               start_dir = 1'b1;
            end
            stop = stop | done;
            fire = done && qualify(cnt_q, cfg_q.range, width_q, delta_q);
         end
         default: begin
            fire = 1'b0;
         end
      endcase
   end

   // APB decode: zero-wait answer, pready raised from the setup cycle
   assign access  = psel & penable & pready_q;
   assign wr      = access & pwrite;
   assign wr_ctrl = wr & (paddr == PQT_OFF_CTRL);
   // Config change or disable throws away any measurement in flight
   assign restart = wr_ctrl | ~cfg_q.enable;

   // Write data merged into the old value, byte lane by byte lane
   logic [31:0]       ctrl_m;
   logic [31:0]       width_m;
   logic [31:0]       delta_m;
   assign ctrl_m  = merge(32'(cfg_q), pwdata, pstrb);
   assign width_m = merge(32'(width_q), pwdata, pstrb);
   assign delta_m = merge(32'(delta_q), pwdata, pstrb);

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q   <= PQT_CFG_RST;
         width_q <= PQT_REG_RST[CNT_W-1:0];
         delta_q <= PQT_REG_RST[CNT_W-1:0];
      end else if (ce && wr) begin
         unique case (paddr)
            PQT_OFF_CTRL: begin
               cfg_q <= pqt_cfg_t'(ctrl_m[PQT_CFG_W-1:0]);
            end
            PQT_OFF_WIDTH: begin
               width_q <= width_m[CNT_W-1:0];
            end
            PQT_OFF_DELTA: begin
               delta_q <= delta_m[CNT_W-1:0];
            end
            default: begin
               cfg_q <= cfg_q;
            end
         endcase
      end
   end

   // APB answer path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= PQT_REG_RST;
      end else if (ce) begin
         pready_q  <= psel & ~penable & ~pready_q;
         if (psel && !penable) begin
            pslverr_q <= 1'b0;
            unique case (paddr)
               PQT_OFF_CTRL:   prdata_q <= 32'(cfg_q);
               PQT_OFF_WIDTH:  prdata_q <= 32'(width_q);
               PQT_OFF_DELTA:  prdata_q <= 32'(delta_q);
               PQT_OFF_MEAS:   prdata_q <= 32'(meas_q);
               PQT_OFF_COUNT:  prdata_q <= tcount_q;
               PQT_OFF_STATUS: begin
                  prdata_q <= PQT_REG_RST;
                  prdata_q[PQT_ST_RUN]  <= run_q;
                  prdata_q[PQT_ST_SEEN] <= seen_q;
                  prdata_q[PQT_ST_DIR]  <= dir_q;
               end
               default: begin
                  prdata_q  <= PQT_REG_RST;
                  pslverr_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // Previous comparator sample and its validity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_q  <= '0;
         seen_q <= 1'b0;
      end else if (ce) begin
         cmp_q  <= cmp_i;
         seen_q <= ~restart;
      end
   end

   // Duration counter, counts sampling cycles and saturates
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
         dir_q <= 1'b0;
         cnt_q <= '0;
      end else if (ce) begin
         if (restart) begin
            run_q <= 1'b0;
            dir_q <= 1'b0;
            cnt_q <= '0;
         end else if (start) begin
            run_q <= 1'b1;
            dir_q <= start_dir;
            cnt_q <= CNT_W'(1);
         end else begin
            if (stop) begin
               run_q <= 1'b0;
            end
            if (run_q && !(&cnt_q)) begin
               cnt_q <= cnt_q + CNT_W'(1);
            end
         end
      end
   end

   // Fall-to-fall counter, counts sampling cycles and saturates
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_run_q <= 1'b0;
         alt_cnt_q <= '0;
      end else if (ce) begin
         if (restart) begin
            alt_run_q <= 1'b0;
            alt_cnt_q <= '0;
         end else if (alt_start) begin
            alt_run_q <= 1'b1;
            alt_cnt_q <= CNT_W'(1);
         end else if (alt_run_q && !(&alt_cnt_q)) begin
            alt_cnt_q <= alt_cnt_q + CNT_W'(1);
         end
      end
   end

   // Trigger pulse, last duration and trigger count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q   <= 1'b0;
         meas_q   <= '0;
         tcount_q <= PQT_REG_RST;
      end else if (ce) begin
         trig_q <= fire & ~restart;
         if (done && !restart) begin
            meas_q <= cnt_q;
         end else if (alt_done && !restart) begin
            meas_q <= alt_cnt_q;
         end
         // A trigger in the clearing cycle still counts
         if (fire && !restart) begin
            if (wr && paddr == PQT_OFF_COUNT) begin
               tcount_q <= 32'h0000_0001;
            end else begin
               tcount_q <= tcount_q + 32'h0000_0001;
            end
         end else if (wr && paddr == PQT_OFF_COUNT) begin
            tcount_q <= PQT_REG_RST;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign trig_o  = trig_q;

endmodule // pqt_core
`default_nettype wire

// ===== bench/pqt_core_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pqt_core_sva #(
   parameter int unsigned CNT_W = 32
) (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       ce,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [pqt_pkg::PQT_AW-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [3:0]                 pstrb,
   input wire pqt_pkg::pqt_cmp_t          cmp_i,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       trig_o
);
   import pqt_pkg::*;
   pqt_cfg_t cfg_q;
   logic     ctrl_wr;
   logic     in_band;

   // Completed control write; strobes ignored, bench writes whole words
   assign ctrl_wr = ce && psel && penable && pready && pwrite
                    && (paddr == PQT_OFF_CTRL);
   assign in_band = cmp_i.lower && !cmp_i.upper;

   // Shadow of the control word, so checks know the active mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= PQT_CFG_RST;
      end else if (ctrl_wr) begin
         cfg_q <= pqt_cfg_t'(pwdata[PQT_CFG_W-1:0]);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_trig_pulse: assert property (trig_o |=> !trig_o)
      else $error("trigger wider than one cycle");
   a_restart_quiet: assert property (ctrl_wr |=> (!trig_o) [*2])
      else $error("trigger right after control write");
   a_reset_quiet: assert property (
      $rose(presetn) |-> (!trig_o) [*3])
      else $error("trigger right after reset");
   a_trig_enabled: assert property (trig_o |-> cfg_q.enable)
      else $error("trigger while disabled");
   a_runt_fall: assert property (
      trig_o && cfg_q.mode == PQT_MODE_RUNT && cfg_q.slope == PQT_SLOPE_POS
      |-> !$past(cmp_i.lower) && $past(cmp_i.lower, 2))
      else $error("runt trigger without lower fall");
   a_win_enter: assert property (
      trig_o && cfg_q.mode == PQT_MODE_WINDOW && cfg_q.vcond == PQT_VC_ENTER
      |-> $past(in_band) && !$past(in_band, 2))
      else $error("enter trigger without entry");
   a_win_exit: assert property (
      trig_o && cfg_q.mode == PQT_MODE_WINDOW && cfg_q.vcond == PQT_VC_EXIT
      |-> !$past(in_band) && $past(in_band, 2))
      else $error("exit trigger without exit");
   a_tout_state: assert property (
      trig_o && cfg_q.mode == PQT_MODE_TIMEOUT && cfg_q.tor != PQT_TO_EITHER
      |-> $past(cmp_i.level) == (cfg_q.tor == PQT_TO_HIGH))
      else $error("timeout fired in wrong state");
   a_intv_rise: assert property (
      trig_o && cfg_q.mode == PQT_MODE_INTERVAL
      && cfg_q.slope == PQT_SLOPE_POS
      |-> $past(cmp_i.level) && !$past(cmp_i.level, 2))
      else $error("interval trigger without rising edge");
   a_slew_stop: assert property (
      trig_o && cfg_q.mode == PQT_MODE_SLEW && cfg_q.slope == PQT_SLOPE_POS
      |-> $past(cmp_i.upper) && !$past(cmp_i.upper, 2))
      else $error("slew trigger without upper crossing");
endmodule // pqt_core_sva

bind pqt_core pqt_core_sva #(.CNT_W(CNT_W)) i_pqt_core_sva (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .cmp_i(cmp_i), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .trig_o(trig_o));
`default_nettype wire

// ===== bench/pqt_afe_model.sv
`timescale 1ns/10ps
`default_nettype none
module pqt_afe_model (
   input  wire logic [1:0]        ana_i,
   output var  pqt_pkg::pqt_cmp_t cmp_o
);
   import pqt_pkg::*;
   // Codes: 0 below lower, 1 lower..level, 2 level..upper, 3 above upper
   always_comb begin
      cmp_o.upper = (ana_i == 2'h3);
      cmp_o.lower = (ana_i != 2'h0);
      cmp_o.level = ana_i[1];
   end
endmodule // pqt_afe_model
`default_nettype wire

// ===== bench/pulse_qualifier_trigger_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_qualifier_trigger_tb;
   import pqt_pkg::*;
   typedef struct {
      int m, r, s, v, t, b, p, q, h, l, e;
   } pqt_row_t;
   localparam int NROW = 28;

   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              ce = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [PQT_AW-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [3:0]        pstrb = 4'hF;
   logic [1:0]        ana = 2'h0;
   pqt_cmp_t          cmp;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              trig_o;
   logic [31:0]       rd;
   logic              err;
   pqt_cfg_t          cfg;
   int                miscompares = 0;
   int                cmp_count = 0;
   int                trig_seen = 0;
   int                t0 = 0;

   // Mode range slope vcond tor, base/pulse/return codes, hold, gap, hits
   // Width 10 and delta 2 for every row; each pulse is played twice
   pqt_row_t rows [NROW] = '{
      '{0,0,0,0,0,0,1,0,5,5,2}, '{0,0,1,0,0,3,2,3,5,5,2},
      '{0,0,0,0,0,0,3,0,5,5,0},
      '{0,1,0,0,0,0,1,0,12,5,2}, '{0,2,0,0,0,0,1,0,12,5,0},
      '{0,3,0,0,0,0,1,0,8,5,2}, '{0,4,0,0,0,0,1,0,8,5,0},
      '{1,3,0,0,0,0,1,0,30,5,2}, '{1,3,0,1,0,0,1,0,30,5,2},
      '{1,3,0,2,0,0,1,0,12,5,2}, '{1,3,0,3,0,1,0,1,9,5,2},
      '{1,4,0,2,0,0,1,0,13,5,2},
      '{1,2,0,2,0,0,1,0,7,5,2}, '{1,1,0,2,0,0,1,0,10,5,0},
      '{2,0,0,0,0,0,2,0,12,3,2}, '{2,0,0,0,1,0,2,0,12,3,0},
      '{2,0,0,0,2,0,2,0,3,12,2},
      '{3,3,0,0,0,0,2,0,5,5,1}, '{3,4,0,0,0,0,2,0,5,5,0},
      '{3,2,0,0,0,0,2,0,3,4,1}, '{3,1,1,0,0,0,2,0,6,7,1},
      '{3,3,2,0,0,0,2,0,5,5,2},
      '{4,3,0,0,0,0,1,3,9,5,1}, '{4,4,0,0,0,0,1,3,9,5,0},
      '{4,2,0,0,0,0,1,3,7,5,1}, '{4,1,1,0,0,3,1,0,12,5,1},
      '{4,3,2,0,0,3,1,0,9,5,1}, '{4,3,0,0,0,3,1,0,9,5,0}
   };

   pqt_afe_model i_pqt_afe_model (.ana_i(ana), .cmp_o(cmp));

   pqt_core #(.CNT_W(16)) i_pqt_core (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .cmp_i(cmp), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_o(trig_o));

   always #2 pclk = ~pclk;

   // Count pulses mid-cycle, clear of the edge that launches them
   always @(negedge pclk) if (trig_o === 1'b1) trig_seen++;

   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One transfer, then an idle cycle so psel never toggles in one step
   task automatic apb(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input string nm, input logic [4:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, exp, rd);
   endtask

   // Disable, load limits, enable last: the enable write restarts tracking
   task automatic run_row(input pqt_row_t w);
      cfg = PQT_CFG_RST;
      cfg.enable = 1'b1;
      cfg.mode = pqt_mode_t'(w.m);
      cfg.range = pqt_range_t'(w.r);
      cfg.slope = pqt_slope_t'(w.s);
      cfg.vcond = pqt_vcond_t'(w.v);
      cfg.tor = pqt_tor_t'(w.t);
      apb(1'b1, PQT_OFF_CTRL, 32'h0000_0000);
      apb(1'b1, PQT_OFF_WIDTH, 32'h0000_000A);
      apb(1'b1, PQT_OFF_DELTA, 32'h0000_0002);
      apb(1'b1, PQT_OFF_COUNT, 32'h0000_0000);
      ana <= w.b[1:0];
      apb(1'b1, PQT_OFF_CTRL, 32'(cfg));
      t0 = trig_seen;
      repeat (3) @(posedge pclk);
      repeat (2) begin
         ana <= w.p[1:0];
         repeat (w.h) @(posedge pclk);
         ana <= w.q[1:0];
         repeat (w.l) @(posedge pclk);
      end
      ana <= w.b[1:0];
      repeat (4) @(posedge pclk);
   endtask

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a < 5; a++) begin
         rdchk("reset value", 5'(a * 4), 32'h0000_0000);
      end
      apb(1'b0, 5'h18, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      chk("unmapped data", 32'h0000_0000, rd);
      apb(1'b1, PQT_OFF_WIDTH, 32'h0000_0ABC);
      rdchk("width", PQT_OFF_WIDTH, 32'h0000_0ABC);
      apb(1'b1, PQT_OFF_MEAS, 32'hFFFF_FFFF);
      rdchk("meas read-only", PQT_OFF_MEAS, 32'h0000_0000);
      for (int i = 0; i < NROW; i++) begin
         run_row(rows[i]);
         chk("pulses", 32'(rows[i].e), 32'(trig_seen - t0));
         rdchk("count", PQT_OFF_COUNT, 32'(rows[i].e));
      end
      // Rise-to-rise of 3 plus 4 cycles is kept as the last duration
      run_row(rows[19]);
      rdchk("interval", PQT_OFF_MEAS, 32'h0000_0007);
      // Restart mid-runt: the half-seen pulse must be forgotten
      cfg.mode = PQT_MODE_RUNT;
      cfg.range = PQT_RNG_ANY;
      cfg.slope = PQT_SLOPE_POS;
      ana <= 2'h0;
      apb(1'b1, PQT_OFF_CTRL, 32'(cfg));
      t0 = trig_seen;
      repeat (3) @(posedge pclk);
      ana <= 2'h1;
      repeat (4) @(posedge pclk);
      apb(1'b1, PQT_OFF_CTRL, 32'(cfg));
      ana <= 2'h0;
      repeat (4) @(posedge pclk);
      chk("restart", 32'h0000_0000, 32'(trig_seen - t0));
      // Clock enable low: a runt seen only while frozen never happened
      t0 = trig_seen;
      ce <= 1'b0;
      ana <= 2'h1;
      repeat (6) @(posedge pclk);
      ana <= 2'h0;
      repeat (2) @(posedge pclk);
      ce <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("frozen", 32'h0000_0000, 32'(trig_seen - t0));
      // Second reset while enabled clears the configuration
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("ctrl after reset", PQT_OFF_CTRL, 32'h0000_0000);
      stop_test;
   end

   // Whole run is near 1650 cycles; this limit means a hang
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test;
   end
endmodule // pulse_qualifier_trigger_tb
`default_nettype wire
